// file: logic/sso_pkg.sv
// constants and types for the sensor serial output port
package sso_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_BASE_NS = 3000;
    localparam logic [11:0] TICK_BASE_CYC = 12'((TICK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] SENT_LOW_TICKS = 10'h005;
    localparam logic [9:0] SENT_HIGH_BASE = 10'h007;
    localparam logic [9:0] CAL_TICKS = 10'h038;
    localparam logic [9:0] PAUSE_MIN = 10'h00C;
    localparam logic [9:0] PAUSE_MAX = 10'h300;
    localparam logic [10:0] MSG_CONST_MIN = 11'h0A6;
    localparam logic [10:0] MSG_CONST_MAX = 11'h40E;
    // ------------------------------------------------------------
    // pulse indices within a message
    // ------------------------------------------------------------
    localparam logic [3:0] P_CAL = 4'h0;
    localparam logic [3:0] P_STATUS = 4'h1;
    localparam logic [3:0] P_DATA0 = 4'h2;
    localparam logic [3:0] P_CRC = 4'h8;
    localparam logic [3:0] P_PAUSE = 4'h9;
    localparam int NIB_DATA = 6;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam logic [3:0] CRC4_SEED = 4'h5;
    localparam logic [3:0] CRC4_POLY = 4'hD;
    localparam logic [2:0] CRC3_SEED = 3'h7;
    localparam logic [2:0] CRC3_POLY = 3'h3;
    // ------------------------------------------------------------
    // psi5 frame limits
    // ------------------------------------------------------------
    localparam int PSI_MAX_BITS = 33;
    localparam int PAY_MAX = 28;
    localparam logic [4:0] RA_MIN = 5'h0A;
    localparam logic [4:0] RA_MAX = 5'h18;
    localparam logic [3:0] RB_MAX = 4'hC;
    localparam logic [2:0] FC_MAX = 3'h4;
    localparam logic [1:0] ST_MAX = 2'h2;
    localparam int START_BITS = 2;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSO_STD = 2'h0,
        SSO_A3 = 2'h1,
        SSO_A4 = 2'h2
    } sso_variant_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SENT = 4'h2,
        ST_PSI = 4'h4,
        ST_FAULT = 4'h8
    } sso_state_t;
endpackage

// file: logic/sso_sent_crc.sv
// sent checksum nibble, recommended and table forms
`timescale 1ns/1ps
module sso_sent_crc (
    // data
    input wire logic [23:0] data_nibbles,
    input wire logic legacy,
    // result
    output logic [3:0] crc
);
    import sso_pkg::*;
    function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] n);
        logic [3:0] r;
        r = c;
        for (int b = 3; b >= 0; b--) begin
            r = {r[2:0], n[b]} ^ (r[3] ? CRC4_POLY : 4'h0);
        end
        return r;
    endfunction
    // ------------------------------------------------------------
    // legacy lookup table, built as constants
    // ------------------------------------------------------------
    logic [3:0] table_rom [256];
    always_comb begin
        for (int i = 0; i < 256; i++) begin
            table_rom[i] = crc_step(i[7:4], i[3:0]);
        end
    end
    logic [3:0] crc_new;
    logic [3:0] crc_leg;
    always_comb begin
        crc_new = CRC4_SEED;
        crc_leg = CRC4_SEED;
        for (int k = NIB_DATA - 1; k >= 0; k--) begin
            crc_new = crc_step(crc_new, data_nibbles[4*k +: 4]);
            crc_leg = table_rom[{crc_leg, data_nibbles[4*k +: 4]}];
        end
        crc_new = crc_step(crc_new, 4'h0);
        crc_leg = table_rom[{crc_leg, 4'h0}];
        crc = legacy ? crc_leg : crc_new;
    end
endmodule

// file: logic/sso_psi_chk.sv
// psi5 error check: crc3 or even parity
`timescale 1ns/1ps
module sso_psi_chk (
    // payload, first bit in index 0
    input wire logic [27:0] payload,
    input wire logic [4:0] pay_len,
    // result
    output logic [2:0] crc,
    output logic parity
);
    import sso_pkg::*;
    always_comb begin
        crc = CRC3_SEED;
        parity = 1'b0;
        for (int i = 0; i < PAY_MAX; i++) begin
            if (i < int'(pay_len)) begin
                crc = {crc[1:0], payload[i]} ^ (crc[2] ? CRC3_POLY : 3'h0);
                parity = parity ^ payload[i];
            end
        end
        for (int z = 0; z < 3; z++) begin
            crc = {crc[1:0], 1'b0} ^ (crc[2] ? CRC3_POLY : 3'h0);
        end
    end
endmodule

// file: logic/sso_port.sv
// sent / psi5 sensor serial output port
`timescale 1ns/1ps
module sso_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // mode and timing
    input wire logic psi_mode,
    input wire logic [1:0] tick_sel,
    input wire sso_pkg::sso_variant_t variant,
    input wire logic a4_nib6_zero,
    input wire logic a4_cnt_zero,
    input wire logic crc_legacy,
    input wire logic counter_clear,
    // pause
    input wire logic pause_en,
    input wire logic pause_align,
    input wire logic [10:0] msg_const_ticks,
    input wire logic align_event,
    // sent data
    input wire logic start,
    input wire logic [3:0] status_nibble,
    input wire logic [11:0] first_nibble_word_reg,
    input wire logic [11:0] second_nibble_word_reg,
    // psi5 sections
    input wire logic sc_en,
    input wire logic serial_channel_bit_low,
    input wire logic serial_channel_bit_high,
    input wire logic [2:0] fc_len,
    input wire logic [3:0] frame_control_bits,
    input wire logic [1:0] st_len,
    input wire logic [1:0] frame_status_bits,
    input wire logic [3:0] rb_len,
    input wire logic [11:0] aux_data_region,
    input wire logic [4:0] ra_len,
    input wire logic [23:0] main_data_region,
    input wire logic use_crc3,
    // protection
    input wire logic over_voltage,
    input wire logic over_current,
    input wire logic line_short,
    // outputs
    output logic sent_out,
    output logic sent_oe,
    output logic psi_sink,
    output logic busy,
    output logic msg_done,
    output logic fault_active,
    output logic [7:0] roll_count
);
    import sso_pkg::*;
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_q <= rst_meta;
        end
    end
    // ------------------------------------------------------------
    // tick divider
    // ------------------------------------------------------------
    logic [11:0] div_cnt;
    logic tick;
    logic [11:0] div_top;
    assign div_top = 12'(TICK_BASE_CYC << tick_sel);
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            div_cnt <= 12'h000;
            tick <= 1'b0;
        end else if (state == ST_IDLE && start) begin
            div_cnt <= 12'h000;
            tick <= 1'b0;
        end else if (div_cnt >= div_top - 12'h001) begin
            div_cnt <= 12'h000;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 12'h001;
            tick <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // psi5 frame assembly
    // ------------------------------------------------------------
    logic [27:0] pay;
    logic [4:0] plen;
    logic [2:0] chk_crc;
    logic chk_par;
    logic [32:0] next_frame;
    logic [5:0] next_flen;
    always_comb begin
        int p;
        int f;
        int rbn;
        int ran;
        p = 0;
        f = 0;
        pay = 28'h000_0000;
        rbn = (rb_len > RB_MAX) ? int'(RB_MAX) : int'(rb_len);
        ran = (ra_len < RA_MIN) ? int'(RA_MIN) : (ra_len > RA_MAX) ? int'(RA_MAX) : int'(ra_len);
        if (sc_en) begin
            pay[0] = serial_channel_bit_low;
            pay[1] = serial_channel_bit_high;
            p = 2;
        end
        for (int i = 0; i < int'(FC_MAX); i++) begin
            if (i < int'(fc_len) && p < PAY_MAX) begin
                pay[p] = frame_control_bits[i];
                p = p + 1;
            end
        end
        for (int i = 0; i < int'(ST_MAX); i++) begin
            if (i < int'(st_len) && p < PAY_MAX) begin
                pay[p] = frame_status_bits[i];
                p = p + 1;
            end
        end
        for (int i = 0; i < int'(RB_MAX); i++) begin
            if (i < rbn && p < PAY_MAX) begin
                pay[p] = aux_data_region[i];
                p = p + 1;
            end
        end
        for (int i = 0; i < int'(RA_MAX); i++) begin
            if (i < ran && p < PAY_MAX) begin
                pay[p] = main_data_region[i];
                p = p + 1;
            end
        end
        plen = 5'(p);
        next_frame = 33'h0_0000_0000;
        for (int i = 0; i < PAY_MAX; i++) begin
            if (i < p) begin
                next_frame[START_BITS + i] = pay[i];
            end
        end
        f = START_BITS + p;
        if (use_crc3) begin
            for (int j = 0; j < 3; j++) begin
                if (f + j < PSI_MAX_BITS) begin
                    next_frame[f + j] = chk_crc[2 - j];
                end
            end
            next_flen = 6'(f + 3);
        end else begin
            if (f < PSI_MAX_BITS) begin
                next_frame[f] = chk_par;
            end
            next_flen = 6'(f + 1);
        end
    end
    sso_psi_chk u_chk (
        .payload(pay),
        .pay_len(plen),
        .crc(chk_crc),
        .parity(chk_par)
    );
    // ------------------------------------------------------------
    // sent nibble selection and checksum
    // ------------------------------------------------------------
    logic [23:0] data_q;
    logic [3:0] stat_q;
    logic [23:0] next_data;
    logic [3:0] crc_nib;
    always_comb begin
        logic [3:0] n1;
        n1 = first_nibble_word_reg[11:8];
        next_data = {first_nibble_word_reg, second_nibble_word_reg};
        if (variant == SSO_A3 || variant == SSO_A4) begin
            next_data[11:4] = roll_count;
            next_data[3:0] = ~n1;
            if (variant == SSO_A4 && a4_cnt_zero) begin
                next_data[11:4] = 8'h00;
            end
            if (variant == SSO_A4 && a4_nib6_zero) begin
                next_data[3:0] = 4'h0;
            end
        end
    end
    sso_sent_crc u_crc (
        .data_nibbles(data_q),
        .legacy(crc_legacy),
        .crc(crc_nib)
    );
    // ------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------
    sso_state_t state;
    logic [3:0] pidx;
    logic [9:0] ptick;
    logic [10:0] msg_ticks;
    logic [9:0] pause_len;
    logic align_seen;
    logic [32:0] frame_q;
    logic [5:0] flen_q;
    logic [5:0] bidx;
    logic half;
    logic fault_any;
    logic [9:0] cur_len;
    logic [3:0] cur_nib;
    logic pulse_end;
    logic [10:0] pause_calc;
    assign fault_any = over_voltage | over_current | line_short;
    always_comb begin
        case (pidx)
            P_STATUS: cur_nib = stat_q;
            P_CRC: cur_nib = crc_nib;
            default: cur_nib = data_q[4*(7 - int'(pidx)) +: 4];
        endcase
        if (pidx == P_CAL) begin
            cur_len = CAL_TICKS;
        end else if (pidx == P_PAUSE) begin
            cur_len = pause_len;
        end else begin
            cur_len = SENT_LOW_TICKS + SENT_HIGH_BASE + 10'(cur_nib);
        end
        if (pidx == P_PAUSE && pause_align) begin
            pulse_end = (ptick + 10'h001 >= PAUSE_MIN && (align_seen || align_event))
                || ptick + 10'h001 >= PAUSE_MAX;
        end else begin
            pulse_end = (ptick + 10'h001 >= cur_len);
        end
        pause_calc = msg_const_ticks - msg_ticks - 11'h001;
        if (msg_const_ticks < MSG_CONST_MIN || msg_const_ticks > MSG_CONST_MAX
            || msg_ticks + 11'h001 >= msg_const_ticks || pause_calc < 11'(PAUSE_MIN)) begin
            pause_calc = 11'(PAUSE_MIN);
        end else if (pause_calc > 11'(PAUSE_MAX)) begin
            pause_calc = 11'(PAUSE_MAX);
        end
    end
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            state <= ST_IDLE;
            pidx <= P_CAL;
            ptick <= 10'h000;
            msg_ticks <= 11'h000;
            pause_len <= PAUSE_MIN;
            align_seen <= 1'b0;
            data_q <= 24'h00_0000;
            stat_q <= 4'h0;
            frame_q <= 33'h0_0000_0000;
            flen_q <= 6'h00;
            bidx <= 6'h00;
            half <= 1'b0;
            msg_done <= 1'b0;
        end else begin
            msg_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (fault_any) begin
                        state <= ST_FAULT;
                    end else if (start && psi_mode) begin
                        frame_q <= next_frame;
                        flen_q <= next_flen;
                        bidx <= 6'h00;
                        half <= 1'b0;
                        state <= ST_PSI;
                    end else if (start) begin
                        data_q <= next_data;
                        stat_q <= status_nibble;
                        pidx <= P_CAL;
                        ptick <= 10'h000;
                        msg_ticks <= 11'h000;
                        state <= ST_SENT;
                    end
                end
                ST_SENT: begin
                    if (fault_any) begin
                        state <= ST_FAULT;
                    end else if (tick) begin
                        msg_ticks <= msg_ticks + 11'h001;
                        if (align_event) begin
                            align_seen <= 1'b1;
                        end
                        if (!pulse_end) begin
                            ptick <= ptick + 10'h001;
                        end else begin
                            ptick <= 10'h000;
                            if (pidx == P_CRC && pause_en) begin
                                pidx <= P_PAUSE;
                                pause_len <= pause_calc[9:0];
                                align_seen <= 1'b0;
                            end else if (pidx == P_CRC || pidx == P_PAUSE) begin
                                state <= ST_IDLE;
                                msg_done <= 1'b1;
                            end else begin
                                pidx <= pidx + 4'h1;
                            end
                        end
                    end
                end
                ST_PSI: begin
                    if (fault_any) begin
                        state <= ST_FAULT;
                    end else if (tick) begin
                        half <= ~half;
                        if (half) begin
                            if (bidx + 6'h01 >= flen_q) begin
                                state <= ST_IDLE;
                                msg_done <= 1'b1;
                            end else begin
                                bidx <= bidx + 6'h01;
                            end
                        end
                    end
                end
                ST_FAULT: begin
                    if (!fault_any) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // rolling counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            roll_count <= 8'h00;
        end else if (counter_clear || state == ST_FAULT) begin
            roll_count <= 8'h00;
        end else if (state == ST_SENT && tick && pulse_end && !fault_any
                     && (pidx == P_CRC || pidx == P_PAUSE) && !(pidx == P_CRC && pause_en)) begin
            roll_count <= roll_count + 8'h01;
        end
    end
    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            sent_out <= 1'b1;
            sent_oe <= 1'b0;
            psi_sink <= 1'b0;
            busy <= 1'b0;
            fault_active <= 1'b0;
        end else begin
            sent_oe <= !fault_any && state != ST_FAULT && !psi_mode;
            sent_out <= !(state == ST_SENT && ptick < SENT_LOW_TICKS);
            psi_sink <= state == ST_PSI && !fault_any
                && (frame_q[bidx] ^ half);
            busy <= state == ST_SENT || state == ST_PSI;
            fault_active <= fault_any || state == ST_FAULT;
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q);
    a_fault_drv_off: assert property (fault_any |=> !sent_oe) else $error("driver on in fault");
    a_short_resume: assert property (state == ST_FAULT && !fault_any |=> state == ST_IDLE)
        else $error("no resume after fault");
    a_low_phase: assert property (state == ST_SENT && ptick < SENT_LOW_TICKS && !fault_any
        |=> !sent_out) else $error("low phase not low");
    a_cal_len: assert property (state == ST_SENT && pidx == P_CAL |-> ptick < CAL_TICKS)
        else $error("cal pulse too long");
    a_pause_max: assert property (state == ST_SENT && pidx == P_PAUSE |-> ptick < PAUSE_MAX)
        else $error("pause too long");
    a_nib6_inv: assert property (state == ST_SENT && variant == SSO_A3 && $stable(variant)
        && $past(state) == ST_IDLE |-> data_q[3:0] == ~data_q[23:20])
        else $error("nibble six not inverted");
    a_cnt_wrap: assert property (roll_count == 8'hFF && !counter_clear && state != ST_FAULT
        && $changed(roll_count) == 1'b0 ##1 $changed(roll_count) |-> roll_count == 8'h00)
        else $error("counter wrap wrong");
    a_start_zero: assert property (state == ST_PSI |-> frame_q[1:0] == 2'h0)
        else $error("start bits not zero");
    a_frame_len: assert property (state == ST_PSI |-> flen_q >= 6'h0D && flen_q <= 6'h21)
        else $error("frame length out of range");
    a_tick_single: assert property (tick |=> !tick) else $error("tick wider than one cycle");
    a_crc_forms_agree: assert property (u_crc.crc_new == u_crc.crc_leg)
        else $error("crc forms differ");
    a_manch_mid: assert property (state == ST_PSI && tick && !half && !fault_any
        ##1 state == ST_PSI && !fault_any |=> psi_sink != $past(psi_sink))
        else $error("no mid-bit edge");
    c_sent_msg: cover property (state == ST_SENT && pidx == P_CRC ##1 state == ST_IDLE);
    c_pause: cover property (state == ST_SENT && pidx == P_PAUSE);
    c_psi_frame: cover property (state == ST_PSI ##1 state == ST_IDLE);
    c_fault: cover property (state == ST_FAULT ##1 state == ST_IDLE);
endmodule

// file: dv/sso_ecu_model.sv
// ecu receiver model: sent pulse periods and psi5 bits
`timescale 1ns/1ps
module sso_ecu_model (
    // lines
    input wire logic clk,
    input wire logic sent_line,
    input wire logic psi_line,
    // decoded
    output int ticks,
    output logic stb,
    output int since,
    output logic [32:0] bits,
    output logic rdy
);
    logic prev = 1'b1;
    // sent period, falling edge to falling edge, in 120-clock ticks
    always @(posedge clk) begin
        stb <= prev & ~sent_line;
        prev <= sent_line;
        since <= (prev & ~sent_line) ? 1 : since + 1;
        ticks <= (since + 60) / 120;
    end
    // psi5 bit from second half level, first rise is mid start bit
    initial begin
        rdy = 1'b0;
        forever begin
            @(posedge psi_line);
            repeat (60) @(posedge clk);
            for (int k = 0; k < 33; k++) begin
                bits[k] = ~psi_line;
                repeat (240) @(posedge clk);
            end
            rdy = ~rdy;
        end
    end
endmodule

// file: dv/test_sensor_serial_output_port.sv
// self-checking bench for the sensor serial output port
`timescale 1ns/1ps
module test_sensor_serial_output_port;
    import sso_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psi_mode = 1'b0, crc_legacy = 1'b0, counter_clear = 1'b0;
    logic pause_en = 1'b0, pause_align = 1'b0, align_event = 1'b0, start = 1'b0;
    logic a4_nib6_zero = 1'b0, a4_cnt_zero = 1'b0, use_crc3 = 1'b1, sc_en = 1'b1;
    logic over_voltage = 1'b0, over_current = 1'b0, line_short = 1'b0;
    logic serial_channel_bit_low = 1'b1, serial_channel_bit_high = 1'b0;
    logic [1:0] tick_sel = 2'h0, st_len = 2'h1, frame_status_bits = 2'h1;
    logic [2:0] fc_len = 3'h3;
    logic [3:0] status_nibble = 4'h0, frame_control_bits = 4'h5, rb_len = 4'h2;
    logic [4:0] ra_len = 5'h0A;
    logic [10:0] msg_const_ticks = 11'h0C8;
    logic [11:0] first_nibble_word_reg = 12'h000, second_nibble_word_reg = 12'h000;
    logic [11:0] aux_data_region = 12'h002;
    logic [23:0] main_data_region = 24'h00_02D5;
    sso_variant_t variant = SSO_STD;
    logic sent_out, sent_oe, psi_sink, busy, msg_done, fault_active, stb, rdy;
    logic [7:0] roll_count;
    logic [32:0] bits;
    int ticks, since, fail_count = 0, checks_done = 0, cyc = 0;
    int pq[$];
    sso_port uut (.*);
    sso_ecu_model ecu (.clk(clk), .sent_line(sent_out), .psi_line(psi_sink), .ticks(ticks),
        .stb(stb), .since(since), .bits(bits), .rdy(rdy));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (stb === 1'b1) pq.push_back(ticks);
        if (cyc == 95000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic go();
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        pq.delete();
    endtask
    task automatic wait_done();
        int k = 0;
        while (msg_done !== 1'b1 && k < 40000) begin
            @(negedge clk);
            k++;
        end
        check(k < 40000, 1);
    endtask
    task automatic sent_msg(input sso_variant_t v, input logic [11:0] a, input logic [11:0] b,
            input logic [7:0] cnt, input logic z, input logic p);
        logic [3:0] n[6];
        logic [3:0] r;
        int sum;
        n = '{a[11:8], a[7:4], a[3:0], b[11:8], b[7:4], b[3:0]};
        if (v != SSO_STD) n[3] = z ? 4'h0 : cnt[7:4];
        if (v != SSO_STD) n[4] = z ? 4'h0 : cnt[3:0];
        if (v != SSO_STD) n[5] = z ? 4'h0 : ~a[11:8];
        r = CRC4_SEED;
        for (int i = 0; i < 28; i++) begin
            r = {r[2:0], (i < 24) ? n[i / 4][3 - i % 4] : 1'b0} ^ (r[3] ? CRC4_POLY : 4'h0);
        end
        @(posedge clk);
        variant <= v;
        first_nibble_word_reg <= a;
        second_nibble_word_reg <= b;
        a4_cnt_zero <= z;
        a4_nib6_zero <= z;
        crc_legacy <= z;
        pause_en <= p;
        go();
        wait_done();
        check(pq[1], CAL_TICKS);
        check(pq[2], 12);
        for (int i = 0; i < 6; i++) check(pq[i + 3], 12 + n[i]);
        check(p ? pq[9] : (since + 60) / 120, 12 + r);
        if (p) begin
            sum = (since + 60) / 120;
            for (int i = 1; i < 10; i++) sum += pq[i];
            check(sum, msg_const_ticks);
        end
        check(roll_count, cnt + 8'h01);
    endtask
    task automatic fault_run();
        @(posedge clk);
        counter_clear <= 1'b1;
        @(posedge clk);
        counter_clear <= 1'b0;
        @(negedge clk);
        check(roll_count, 0);
        go();
        repeat (300) @(posedge clk);
        over_voltage <= 1'b1;
        repeat (5) @(negedge clk);
        check({sent_oe, fault_active}, 2'b01);
        @(posedge clk);
        over_voltage <= 1'b0;
        repeat (10) @(negedge clk);
        check({sent_oe, sent_out, busy, fault_active, roll_count}, 12'hC00);
    endtask
    task automatic psi_frame(input logic c);
        logic [17:0] pay;
        logic [2:0] r;
        logic [32:0] e;
        logic o;
        int k = 0;
        pay = {main_data_region[9:0], aux_data_region[1:0], frame_status_bits[0],
            frame_control_bits[2:0], serial_channel_bit_high, serial_channel_bit_low};
        r = CRC3_SEED;
        for (int i = 0; i < 21; i++) begin
            r = {r[1:0], (i < 18) ? pay[i] : 1'b0} ^ (r[2] ? CRC3_POLY : 3'h0);
        end
        e = c ? {10'h000, r[0], r[1], r[2], pay, 2'b00} : {12'h000, ^pay, pay, 2'b00};
        o = rdy;
        @(posedge clk);
        psi_mode <= 1'b1;
        use_crc3 <= c;
        go();
        while (rdy === o && k < 9000) begin
            @(negedge clk);
            k++;
        end
        check(bits & (c ? 33'h0_007F_FFFF : 33'h0_001F_FFFF), e);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({sent_out, psi_sink}, 2'b10);
        sent_msg(SSO_STD, 12'h123, 12'h123, 8'h00, 1'b0, 1'b1);
        sent_msg(SSO_A3, 12'h851, 12'h000, 8'h01, 1'b0, 1'b0);
        sent_msg(SSO_A4, 12'h001, 12'h000, 8'h02, 1'b1, 1'b0);
        fault_run();
        psi_frame(1'b1);
        psi_frame(1'b0);
        give_verdict();
    end
endmodule
